// ===== interval_timer_counter.v
`timescale 1ns/100ps
`include "interval_timer_regs.vh"
module interval_timer_counter #(
	parameter PRESCALE = `CLK_FREQ_KHZ / `TIMER_SRC_KHZ
) (
	input  wire       clk,
	input  wire       rst,
	input  wire [4:0] busAddr,
	input  wire       busWrite,
	input  wire       busRead,
	input  wire [7:0] busWriteData,
	output reg  [7:0] busReadData,
	output reg        busReadValid,
	input  wire       isolatedInputFifteen,
	input  wire       eventGate,
	output wire       timerZeroOut,
	output wire       timerOut,
	output wire       eventOut
);
	// ---------------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------------
	// One-hot select of the three data ports
	function [2:0] portSel;
		input [4:0] a;
		begin
			portSel = {a == `EVENT_PORT_TWO, a == `COUNT_PORT_ONE,
				a == `COUNT_PORT_ZERO};
		end
	endfunction

	// Decrement by one in binary or in four decimal digits
	function [15:0] decOne;
		input [15:0] v;
		input        bcd;
		integer      i;
		reg          borrow;
		reg [3:0]    d;
		begin
			decOne = v;
			borrow = 1'b1;
			if (!bcd) begin
				decOne = v - `COUNT_ONE;
			end else begin
				for (i = 0; i < 4; i = i + 1) begin
					d = v[i*4 +: 4];
					if (borrow) begin
						if (d == 4'h0) begin
							d = 4'h9; // Borrow ripples on
						end else begin
							d = d - 4'h1;
							borrow = 1'b0;
						end
					end
					decOne[i*4 +: 4] = d;
				end
			end
		end
	endfunction

	// Codes 6 and 7 alias modes 2 and 3
	function [2:0] effMode;
		input [2:0] m;
		begin
			effMode = m[1] ? {1'b0, m[1:0]} : m;
		end
	endfunction

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	localparam [4:0] PRESCALE_LAST = PRESCALE[4:0] - 5'h01;

	wire [2:0] dataWr = busWrite ? portSel(busAddr) : 3'h0; // [RULE20]
	wire [2:0] dataRd = busRead ? portSel(busAddr) : 3'h0;
	wire       ctrlWr = busWrite && (busAddr == `CONTROL_WORD);
	wire [1:0] wrSel  = busWriteData[`SEL_HI:`SEL_LO];
	wire [1:0] wrAcc  = busWriteData[`ACC_HI:`ACC_LO];
	// Both select bits high turn the word into read-back
	wire       readBack = (wrSel == `SEL_READBACK); // [RULE2]

	// ---------------------------------------------------------------
	// Clock sources
	// ---------------------------------------------------------------
	wire [1:0] pinSync;       // Synced event pin and gate
	reg  [4:0] prescaleCount; // 250 MHz down to 10 MHz
	reg        prescaleTick;  // One cycle per 10 MHz period
	reg        pinPrev;       // Last synced event level
	reg        zeroPrev;      // Last counter 0 output
	wire [2:0] tick;          // Count strobe per channel
	wire [2:0] gateLevel;     // Gate per channel

	bit_synchronizer #(
		.WIDTH   (2)
	) pinSyncer (
		.clk     (clk),
		.rst     (rst),
		.asyncIn ({eventGate, isolatedInputFifteen}),
		.syncOut (pinSync)
	);

	// Prescaler and edge history for the cascade and event pin
	always @(posedge clk) begin
		if (rst) begin
			prescaleCount <= 5'h00;
			prescaleTick <= 1'b0;
			pinPrev <= 1'b1; // Idle pin level, no false fall
			zeroPrev <= 1'b0;
		end else begin
			prescaleTick <= (prescaleCount == PRESCALE_LAST);
			if (prescaleCount == PRESCALE_LAST) begin
				prescaleCount <= 5'h00;
			end else begin
				prescaleCount <= prescaleCount + 5'h01;
			end
			pinPrev <= pinSync[0];
			zeroPrev <= timerZeroOut;
		end
	end

	// Counter 1 counts falling edges of counter 0 output, so the
	// pair forms one long timer; counter 2 counts pin falls
	assign tick[0] = prescaleTick; // [RULE21]
	assign tick[1] = zeroPrev && !timerZeroOut; // [RULE21]
	assign tick[2] = pinPrev && !pinSync[0]; // [RULE21]
	// Timer gates are strapped enabled
	assign gateLevel = {pinSync[1], 2'h3}; // [RULE21]

	// ---------------------------------------------------------------
	// Counter channels
	// ---------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : chan
			localparam [1:0] CH_ID = ch;
			reg  [5:0]  ctrl;        // Access, mode, decimal flag
			reg  [15:0] initCount;   // Last complete count written
			reg  [15:0] liveCount;   // Counting element
			reg  [15:0] holdCount;   // Latched count
			reg  [7:0]  statusByte;  // Latched status
			reg  [7:0]  writeLow;    // First byte of a pair
			reg         outLevel;    // Counter output
			reg         nullCount;   // Count transferred flag
			reg         armed;       // Counting enabled
			reg         loadPending; // New count awaits transfer
			reg         countValid;  // A count exists since mode set
			reg         trigPending; // Gate rise awaits a tick
			reg         gatePrev;    // Last gate level
			reg         writeSecond; // Next write is high byte
			reg         readSecond;  // Next read is high byte
			reg         countHeld;   // Hold register in use
			reg         statusHeld;  // Status byte in use
			wire        gate = gateLevel[ch];
			wire [1:0]  acc  = ctrl[`ACC_HI:`ACC_LO];
			wire [2:0]  mode = effMode(ctrl[`MODE_HI:`MODE_LO]);
			wire        bcd  = ctrl[`BCD_BIT]; // [RULE1]
			wire [15:0] dec1 = decOne(liveCount, bcd); // [RULE1]
			wire [15:0] dec2 = decOne(dec1, bcd);
			wire [15:0] dec3 = decOne(dec2, bcd);
			// Odd counts take one step in high phase, three in low
			wire [15:0] sqStep = liveCount[0] ?
				(outLevel ? dec1 : dec3) : dec2; // [RULE13] [RULE14]
			wire        pick = busWriteData[`RB_PICK_LO + ch]; // [RULE5]
			wire        modeWr = ctrlWr && !readBack &&
				(wrSel == CH_ID) && (wrAcc != `ACC_LATCH); // [RULE22]
			wire        latchCmd = ctrlWr && ((!readBack &&
				(wrSel == CH_ID) && (wrAcc == `ACC_LATCH)) ||
				(readBack && !busWriteData[`RB_COUNT_N] && pick));
			wire        statusCmd = ctrlWr && readBack &&
				!busWriteData[`RB_STATUS_N] && pick; // [RULE4]
			wire [15:0] readSrc = countHeld ? holdCount : liveCount;
			// Status first, then held count, then live count
			wire [7:0]  rdByte = statusHeld ? statusByte :
				((acc == `ACC_HIGH) || ((acc == `ACC_BOTH) && readSecond)) ?
				readSrc[15:8] : readSrc[7:0]; // [RULE4] [RULE24]

			// Counting, bus side effects; later statements win
			always @(posedge clk) begin
				if (rst) begin
					ctrl <= `CTRL_RESET;
					initCount <= `COUNT_RESET;
					liveCount <= `COUNT_RESET;
					holdCount <= `COUNT_RESET;
					statusByte <= `BYTE_ZERO;
					writeLow <= `BYTE_ZERO;
					outLevel <= 1'b0;
					nullCount <= 1'b0;
					armed <= 1'b0;
					loadPending <= 1'b0;
					countValid <= 1'b0;
					trigPending <= 1'b0;
					gatePrev <= 1'b1; // Idle gate level, no false rise
					writeSecond <= 1'b0;
					readSecond <= 1'b0;
					countHeld <= 1'b0;
					statusHeld <= 1'b0;
				end else begin
					gatePrev <= gate;
					// Gate rise is kept until the next count strobe
					if (gate && !gatePrev) begin
						trigPending <= 1'b1;
					end else if (tick[ch]) begin
						trigPending <= 1'b0;
					end
					if (tick[ch]) begin
						case (mode)
						`MODE_ZERO, `MODE_FOUR: begin
							if (loadPending) begin
								liveCount <= initCount; // [RULE15]
								loadPending <= 1'b0;
								nullCount <= 1'b1; // [RULE7]
								armed <= 1'b1;
							end else if (armed && gate) begin
								liveCount <= dec1; // [RULE8]
								if (dec1 == `COUNT_RESET) begin
									if (mode == `MODE_ZERO) begin
										outLevel <= 1'b1; // [RULE8]
									end else begin
										outLevel <= 1'b0; // [RULE15]
										armed <= 1'b0;
									end
								end
							end
							if ((mode == `MODE_FOUR) && !outLevel) begin
								outLevel <= 1'b1; // [RULE15]
							end
						end
						`MODE_ONE, `MODE_FIVE: begin
							// Each trigger reloads, so both retrigger
							if (trigPending && countValid) begin
								liveCount <= initCount; // [RULE10] [RULE16]
								nullCount <= 1'b1;
								armed <= 1'b1;
								loadPending <= 1'b0;
								if (mode == `MODE_ONE) begin
									outLevel <= 1'b0; // [RULE10]
								end
							end else if (armed) begin
								liveCount <= dec1;
								if (dec1 == `COUNT_RESET) begin
									if (mode == `MODE_ONE) begin
										outLevel <= 1'b1; // [RULE10]
									end else begin
										outLevel <= 1'b0; // [RULE16]
										armed <= 1'b0;
									end
								end
							end
							if ((mode == `MODE_FIVE) && !outLevel) begin
								outLevel <= 1'b1; // [RULE16]
							end
						end
						`MODE_TWO, `MODE_THREE: begin
							if (!gate) begin
								outLevel <= 1'b1; // [RULE12]
							end else if ((loadPending && !armed) ||
								(trigPending && countValid)) begin
								liveCount <= initCount; // [RULE12]
								outLevel <= 1'b1;
								armed <= 1'b1;
								loadPending <= 1'b0;
								nullCount <= 1'b1;
							end else if (armed && (mode == `MODE_TWO)) begin
								if (liveCount == `COUNT_TWO) begin
									liveCount <= dec1;
									outLevel <= 1'b0; // [RULE11]
								end else if (liveCount == `COUNT_ONE) begin
									// Reload at period end only
									liveCount <= initCount; // [RULE11]
									outLevel <= 1'b1;
									loadPending <= 1'b0;
									nullCount <= 1'b1;
								end else begin
									liveCount <= dec1;
								end
							end else if (armed) begin
								if (sqStep == `COUNT_RESET) begin
									outLevel <= !outLevel; // [RULE13]
									liveCount <= initCount; // [RULE14]
									loadPending <= 1'b0;
									nullCount <= 1'b1;
								end else begin
									liveCount <= sqStep; // [RULE13]
								end
							end
						end
						default: begin
							armed <= armed;
						end
						endcase
					end
					// Reads advance byte order and release latches
					if (dataRd[ch]) begin
						if (statusHeld) begin
							statusHeld <= 1'b0; // [RULE4]
						end else if (acc == `ACC_BOTH) begin
							readSecond <= !readSecond;
							if (readSecond) begin
								countHeld <= 1'b0; // [RULE24]
							end
						end else begin
							countHeld <= 1'b0; // [RULE24]
						end
					end
					// A second latch before readout is ignored
					if (latchCmd && !countHeld) begin
						holdCount <= liveCount; // [RULE19] [RULE3]
						countHeld <= 1'b1;
					end
					if (statusCmd && !statusHeld) begin
						statusByte <= {outLevel, nullCount, ctrl}; // [RULE6]
						statusHeld <= 1'b1; // [RULE4]
					end
					if (dataWr[ch]) begin
						if ((acc == `ACC_BOTH) && !writeSecond) begin
							writeLow <= busWriteData;
							writeSecond <= 1'b1;
							if (mode == `MODE_ZERO) begin
								armed <= 1'b0; // [RULE9]
							end
						end else begin
							// Count complete: queue transfer
							if (acc == `ACC_HIGH) begin
								initCount <= {busWriteData, `BYTE_ZERO};
							end else if (acc == `ACC_LOW) begin
								initCount <= {`BYTE_ZERO, busWriteData};
							end else begin
								initCount <= {busWriteData, writeLow};
							end
							writeSecond <= 1'b0;
							loadPending <= 1'b1; // [RULE9] [RULE23]
							nullCount <= 1'b0; // [RULE7]
							countValid <= 1'b1;
							if (mode == `MODE_ZERO) begin
								outLevel <= 1'b0; // [RULE8]
							end
						end
					end
					// Mode write restarts the channel from scratch
					if (modeWr) begin
						ctrl <= busWriteData[`ACC_HI:`BCD_BIT]; // [RULE22]
						outLevel <= (effMode(busWriteData[`MODE_HI:`MODE_LO])
							!= `MODE_ZERO); // [RULE8] [RULE15]
						armed <= 1'b0;
						loadPending <= 1'b0;
						countValid <= 1'b0;
						nullCount <= 1'b0;
						trigPending <= 1'b0;
						writeSecond <= 1'b0;
						readSecond <= 1'b0;
						countHeld <= 1'b0;
						statusHeld <= 1'b0;
					end
				end
			end
		end
	endgenerate

	assign timerZeroOut = chan[0].outLevel;
	assign timerOut = chan[1].outLevel;
	assign eventOut = chan[2].outLevel;

	// ---------------------------------------------------------------
	// Read data register
	// ---------------------------------------------------------------
	// Data arrive one cycle after the read strobe; control port and
	// unmapped offsets read as zero
	always @(posedge clk) begin
		if (rst) begin
			busReadData <= `BYTE_ZERO;
			busReadValid <= 1'b0;
		end else begin
			busReadValid <= busRead;
			if (dataRd[0]) begin
				busReadData <= chan[0].rdByte;
			end else if (dataRd[1]) begin
				busReadData <= chan[1].rdByte;
			end else if (dataRd[2]) begin
				busReadData <= chan[2].rdByte;
			end else begin
				busReadData <= `BYTE_ZERO;
			end
		end
	end
endmodule // interval_timer_counter

// ===== interval_timer_regs.vh
// Notes on behaviour
// RULE1: Decimal bit picks BCD 0-9999 else binary
// RULE2: Both select bits set means read-back command
// RULE3: Read-back count request low latches picked counts
// RULE4: Read-back status request low latches status byte
// RULE5: Each pick bit includes its counter
// RULE6: Status holds output, null count, programmed fields
// RULE7: Null count reads one after count transfer
// RULE8: Mode 0 low until terminal, then high
// RULE9: Mode 0 first byte stops, second restarts
// RULE10: Mode 1 retriggerable one-shot from gate edge
// RULE11: Mode 2 one-clock low pulse each period
// RULE12: Mode 2 gate low forces high, edge restarts
// RULE13: Mode 3 even count steps by two
// RULE14: Mode 3 odd count high longer by one
// RULE15: Mode 4 strobe after load, gate inhibits
// RULE16: Mode 5 strobe after gate rising edge
// RULE17: Host writes control byte before count
// RULE18: Host keeps programmed byte order for pairs
// RULE19: Latch command freezes count in hold register
// RULE20: Four separate ports, any programming order
// RULE21: Counters 0,1 cascaded at 10 MHz, 2 events
// RULE22: Control word selects counter, access, mode
// RULE23: Counts from 2 up to 65535 accepted
// RULE24: Latched value frozen until fully read
`ifndef INTERVAL_TIMER_REGS_VH
`define INTERVAL_TIMER_REGS_VH
// ---------------------------------------------------------------
// Port offsets
// ---------------------------------------------------------------
`define COUNT_PORT_ZERO 5'h18
`define COUNT_PORT_ONE  5'h19
`define EVENT_PORT_TWO  5'h1a
`define CONTROL_WORD    5'h1b
// ---------------------------------------------------------------
// Control word fields
// ---------------------------------------------------------------
`define SEL_HI      7
`define SEL_LO      6
`define ACC_HI      5
`define ACC_LO      4
`define MODE_HI     3
`define MODE_LO     1
`define BCD_BIT     0
`define RB_COUNT_N  5
`define RB_STATUS_N 4
`define RB_PICK_LO  1
`define SEL_READBACK 2'h3
`define ACC_LATCH   2'h0
`define ACC_LOW     2'h1
`define ACC_HIGH    2'h2
`define ACC_BOTH    2'h3
`define MODE_ZERO   3'h0
`define MODE_ONE    3'h1
`define MODE_TWO    3'h2
`define MODE_THREE  3'h3
`define MODE_FOUR   3'h4
`define MODE_FIVE   3'h5
// ---------------------------------------------------------------
// Reset values and count constants
// ---------------------------------------------------------------
`define CTRL_RESET  6'h00
`define COUNT_RESET 16'h0000
`define COUNT_ONE   16'h0001
`define COUNT_TWO   16'h0002
`define BYTE_ZERO   8'h00
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_FREQ_KHZ  250000
`define TIMER_SRC_KHZ 10000
`endif

// ===== bit_synchronizer.v
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Two-stage synchroniser for asynchronous pins
// ---------------------------------------------------------------
module bit_synchronizer #(
	parameter WIDTH = 1
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] asyncIn,
	output wire [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stageOne; // Metastable stage, read only below
	reg [WIDTH-1:0] stageTwo; // Settled copy

	// Both stages preset high to match the idle pins, so release of
	// reset shows no false edge; a pin idling low would see one fall
	always @(posedge clk) begin
		if (rst) begin
			stageOne <= {WIDTH{1'b1}};
			stageTwo <= {WIDTH{1'b1}};
		end else begin
			stageOne <= asyncIn;
			stageTwo <= stageOne;
		end
	end

	assign syncOut = stageTwo;
endmodule // bit_synchronizer

// ===== interval_timer_properties.sv
`timescale 1ns/100ps
`include "interval_timer_regs.vh"
module interval_timer_properties #(
	parameter PRESCALE = 2
) (
	input wire       clk,
	input wire       rst,
	input wire [4:0] busAddr,
	input wire       busWrite,
	input wire       busRead,
	input wire [7:0] busWriteData,
	input wire [7:0] busReadData,
	input wire       busReadValid,
	input wire       timerZeroOut,
	input wire       eventOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// -------------------------------------------------------
	// Helper logic
	// -------------------------------------------------------
	reg  [2:0]  modeZero;  // Mode last programmed into counter 0
	reg  [15:0] lowRun;    // Cycles counter 0 output has been low
	wire        ctlWr = busWrite && busAddr == `CONTROL_WORD;
	// Track mode writes; latch commands leave the mode alone
	always @(posedge clk) begin
		if (rst) begin
			modeZero <= 3'h0;
			lowRun   <= 16'h0000;
		end else begin
			if (ctlWr && busWriteData[7:6] == 2'h0 &&
			    busWriteData[5:4] != 2'h0)
				modeZero <= busWriteData[3:1];
			lowRun <= timerZeroOut ? 16'h0000 : lowRun + 16'h0001;
		end
	end
	// -------------------------------------------------------
	// Assertions
	// -------------------------------------------------------
	chk_read_answer: assert property (busRead |=> busReadValid)
		else $error("read not answered next cycle");
	chk_answer_cause: assert property (busReadValid |-> $past(busRead))
		else $error("read answer without request");
	chk_idle_zero: assert property (!busReadValid |-> busReadData == 8'h00)
		else $error("read data not zero when idle");
	chk_ctrl_reads_zero: assert property (busRead &&
		busAddr == `CONTROL_WORD |=> busReadData == 8'h00)
		else $error("control port read not zero");
	chk_unmapped_zero: assert property (busRead &&
		busAddr < `COUNT_PORT_ZERO |=> busReadData == 8'h00)
		else $error("unmapped read not zero");
	chk_reset_quiet: assert property (disable iff (1'b0) rst |=>
		!busReadValid && !timerZeroOut && !eventOut)
		else $error("outputs active after reset");
	chk_mode_zero_low: assert property (ctlWr && busWriteData[7:6] == 2'h0 &&
		busWriteData[5:4] != 2'h0 && busWriteData[3:1] == 3'h0
		|-> ##2 !timerZeroOut)
		else $error("mode zero write left output high");
	// Modes 2 and 4 hold low for exactly one tick
	chk_strobe_width: assert property ($rose(timerZeroOut) &&
		$past(modeZero, 2) == modeZero &&
		(modeZero == 3'h2 || modeZero == 3'h4) |-> lowRun == PRESCALE)
		else $error("low pulse width wrong");
	cover property ($rose(timerZeroOut));
	cover property ($rose(eventOut));
	cover property (busReadValid && busReadData != 8'h00);
endmodule // interval_timer_properties
bind interval_timer_counter interval_timer_properties #(
	.PRESCALE(PRESCALE)
) interval_timer_properties_inst (
	.clk(clk), .rst(rst), .busAddr(busAddr), .busWrite(busWrite),
	.busRead(busRead), .busWriteData(busWriteData),
	.busReadData(busReadData), .busReadValid(busReadValid),
	.timerZeroOut(timerZeroOut), .eventOut(eventOut)
);

// ===== host_port_model.sv
`timescale 1ns/100ps
`include "interval_timer_regs.vh"
module host_port_model (
	input  wire       clk,
	output reg  [4:0] busAddr,
	output reg        busWrite,
	output reg        busRead,
	output reg  [7:0] busWriteData,
	input  wire [7:0] busReadData,
	input  wire       busReadValid
);
	// Bus idle from time zero
	initial begin
		busAddr      = 5'h00;
		busWrite     = 1'b0;
		busRead      = 1'b0;
		busWriteData = 8'h00;
	end
	// One byte write, held across exactly one rising edge
	task writeByte(input [4:0] a, input [7:0] d);
		begin
			@(negedge clk);
			busAddr      = a;
			busWriteData = d;
			busWrite     = 1'b1;
			@(negedge clk);
			busWrite     = 1'b0;
			// Released data is inverted so a stale byte never looks valid
			busWriteData = ~d;
		end
	endtask
	// One byte read; a missing answer comes back unknown
	task readByte(input [4:0] a, output [7:0] d);
		begin
			@(negedge clk);
			busAddr = a;
			busRead = 1'b1;
			@(negedge clk);
			busRead = 1'b0;
			d = busReadValid ? busReadData : 8'hxx;
		end
	endtask
	// Control byte first, then count bytes in programmed order
	task writeCount(input [4:0] a, input [7:0] ctrl, input [15:0] v);
		begin
			writeByte(`CONTROL_WORD, ctrl);
			if (ctrl[4]) writeByte(a, v[7:0]);
			if (ctrl[5]) writeByte(a, v[15:8]);
		end
	endtask
	// Paired read, low byte then high byte
	task readCount(input [4:0] a, output [15:0] v);
		begin
			readByte(a, v[7:0]);
			readByte(a, v[15:8]);
		end
	endtask
endmodule // host_port_model

// ===== interval_timer_counter_bench.sv
`timescale 1ns/100ps
`include "interval_timer_regs.vh"
module interval_timer_counter_bench;
	// -------------------------------------------------------
	// Signals
	// -------------------------------------------------------
	localparam PRESCALE = 2;  // Short tick keeps the run brief
	reg          clk;
	reg          rst;
	reg          isolatedInputFifteen;
	reg          eventGate;
	wire [4:0]   busAddr;
	wire         busWrite;
	wire         busRead;
	wire [7:0]   busWriteData;
	wire [7:0]   busReadData;
	wire         busReadValid;
	wire         timerZeroOut;
	wire         timerOut;
	wire         eventOut;
	int          fail_count;
	int          compares;
	int          n;
	int          hi;
	logic [15:0] v1;
	logic [15:0] v2;
	logic [7:0]  b;
	interval_timer_counter #(
		.PRESCALE(PRESCALE)
	) interval_timer_counter_inst (
		.clk(clk), .rst(rst), .busAddr(busAddr), .busWrite(busWrite),
		.busRead(busRead), .busWriteData(busWriteData),
		.busReadData(busReadData), .busReadValid(busReadValid),
		.isolatedInputFifteen(isolatedInputFifteen),
		.eventGate(eventGate), .timerZeroOut(timerZeroOut),
		.timerOut(timerOut), .eventOut(eventOut)
	);
	host_port_model host_port_model_inst (
		.clk(clk), .busAddr(busAddr), .busWrite(busWrite),
		.busRead(busRead), .busWriteData(busWriteData),
		.busReadData(busReadData), .busReadValid(busReadValid)
	);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// -------------------------------------------------------
	// Checking helpers
	// -------------------------------------------------------
	task checkVal(input [15:0] exp, input [15:0] got);
		begin
			compares++;
			if (got !== exp) begin
				fail_count++;
				$display("Error at %0t: expected %h, got %h", $time, exp, got);
			end
		end
	endtask
	task checkBit(input logic exp, input logic got);
		checkVal({15'h0000, exp}, {15'h0000, got});
	endtask
	function logic pick(input int sel);
		pick = sel == 0 ? timerZeroOut : sel == 1 ? timerOut : eventOut;
	endfunction
	// Cycles until an output shows a level; capped so a hang shows
	task waitLevel(input int sel, input logic lvl, output int cnt);
		begin
			cnt = 0;
			while (pick(sel) !== lvl && cnt < 400) begin
				@(negedge clk);
				cnt++;
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("Compares %0d, mismatches %0d", compares, fail_count);
			if (fail_count == 0 && compares > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// -------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------
	task testPorts;
		begin
			checkBit(1'b0, timerZeroOut);
			host_port_model_inst.readByte(`CONTROL_WORD, b);
			checkVal(16'h0000, {8'h00, b});
			host_port_model_inst.writeByte(5'h05, 8'h5a);
			host_port_model_inst.readByte(5'h05, b);
			checkVal(16'h0000, {8'h00, b});
		end
	endtask
	// Mode 0 with plain latch, read-back latch and status byte
	task testModeZero;
		begin
			host_port_model_inst.writeCount(`COUNT_PORT_ZERO, 8'h30, 16'd100);
			checkBit(1'b0, timerZeroOut);
			repeat (4) @(negedge clk);
			host_port_model_inst.writeByte(`CONTROL_WORD, 8'h00);
			repeat (40) @(negedge clk);
			host_port_model_inst.readCount(`COUNT_PORT_ZERO, v1);
			checkBit(1'b1, v1 <= 16'd100 && v1 > 16'd90);
			host_port_model_inst.writeByte(`CONTROL_WORD, 8'hd2);
			repeat (40) @(negedge clk);
			host_port_model_inst.readCount(`COUNT_PORT_ZERO, v2);
			checkBit(1'b1, v2 < v1 - 16'd10 && v2 > v1 - 16'd60);
			waitLevel(0, 1'b1, n);
			checkBit(1'b1, n > 0 && n < 400);
			host_port_model_inst.writeByte(`CONTROL_WORD, 8'he2);
			host_port_model_inst.readByte(`COUNT_PORT_ZERO, b);
			checkVal(16'h00f0, {8'h00, b});
		end
	endtask
	// Steady high and low spans of a periodic mode, in cycles
	task testPeriod(input [7:0] ctrl, input [15:0] cnt,
	                input int expHi, input int expLo);
		begin
			host_port_model_inst.writeCount(`COUNT_PORT_ZERO, ctrl, cnt);
			waitLevel(0, 1'b0, n);
			waitLevel(0, 1'b1, n);
			waitLevel(0, 1'b0, hi);
			waitLevel(0, 1'b1, n);
			checkVal(expHi[15:0], hi[15:0]);
			checkVal(expLo[15:0], n[15:0]);
		end
	endtask
	task testStrobe;
		begin
			host_port_model_inst.writeByte(`CONTROL_WORD, 8'h38);
			repeat (2) @(negedge clk);
			checkBit(1'b1, timerZeroOut);
			host_port_model_inst.writeByte(`COUNT_PORT_ZERO, 8'h03);
			host_port_model_inst.writeByte(`COUNT_PORT_ZERO, 8'h00);
			waitLevel(0, 1'b0, n);
			waitLevel(0, 1'b1, n);
			checkVal(16'(PRESCALE), n[15:0]);
			repeat (20) @(negedge clk);
			checkBit(1'b1, timerZeroOut);
		end
	endtask
	// Counter 1 counts the falls of counter 0
	task testCascade;
		begin
			host_port_model_inst.writeCount(`COUNT_PORT_ONE, 8'h70, 16'd3);
			checkBit(1'b0, timerOut);
			host_port_model_inst.writeCount(`COUNT_PORT_ZERO, 8'h34, 16'd2);
			waitLevel(1, 1'b1, n);
			checkBit(1'b1, n >= 8 && n < 400);
		end
	endtask
	task pulsePin(input int k);
		repeat (k) begin
			repeat (4) @(negedge clk);
			isolatedInputFifteen = 1'b0;
			repeat (4) @(negedge clk);
			isolatedInputFifteen = 1'b1;
		end
	endtask
	// Event counter, low byte only; first fall loads the count
	task testEvents;
		begin
			host_port_model_inst.writeCount(`EVENT_PORT_TWO, 8'h90, 16'd3);
			pulsePin(3);
			repeat (8) @(negedge clk);
			checkBit(1'b0, eventOut);
			pulsePin(1);
			repeat (8) @(negedge clk);
			checkBit(1'b1, eventOut);
		end
	endtask
	// Gated modes on counter 2, count 3: a gate rise arms a trigger
	// that the next pin fall fires; levels after three and four falls
	task testTrigger(input [7:0] ctrl, input logic early,
	                 input logic late);
		begin
			host_port_model_inst.writeCount(`EVENT_PORT_TWO, ctrl, 16'd3);
			checkBit(1'b1, eventOut);
			@(negedge clk);
			eventGate = 1'b0;
			repeat (4) @(negedge clk);
			eventGate = 1'b1;
			pulsePin(3);
			repeat (8) @(negedge clk);
			checkBit(early, eventOut);
			pulsePin(1);
			repeat (8) @(negedge clk);
			checkBit(late, eventOut);
		end
	endtask
	// -------------------------------------------------------
	// Main sequence and watchdog
	// -------------------------------------------------------
	initial begin
		fail_count = 0;
		compares = 0;
		rst = 1'b1;
		isolatedInputFifteen = 1'b1;
		eventGate = 1'b1;
		repeat (20) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		testPorts;
		testModeZero;
		testPeriod(8'h34, 16'd5, 8, 2);
		testPeriod(8'h36, 16'd5, 6, 4);
		testPeriod(8'h36, 16'd4, 4, 4);
		testPeriod(8'h35, 16'h0010, 18, 2);
		testStrobe;
		testCascade;
		testEvents;
		testTrigger(8'h92, 1'b0, 1'b1);
		testTrigger(8'h9a, 1'b1, 1'b0);
		report_and_stop;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		report_and_stop;
	end
endmodule // interval_timer_counter_bench
